//--- core/pboa_pkg.sv
/*
 * Shared constants for the playback output alignment pair: stream widths,
 * delay buffer size, link timing, control register map and states.
 * Assumes a single 125 MHz reference clock on both ends.
 */
package pboa_pkg;
    localparam int NSTR = 32;
    localparam int SEL_W = 5;
    localparam int WORD_W = NSTR + 2;
    localparam int DLY_AW = 6;
    localparam int DLY_DEPTH = 64;
    localparam int REF_PERIOD_NS = 8;
    localparam int PROC_PERIOD_NS = 128;
    localparam int PROC_HALF = PROC_PERIOD_NS / (2 * REF_PERIOD_NS);
    localparam logic [31:0] SEC_CYC_DEF = 32'(1000000000 / PROC_PERIOD_NS);
    localparam logic [31:0] MON_LEN = 32'h0000_0010;
    localparam int CFG_AW = 8;
    localparam logic [CFG_AW-1:0] A_CTRL = 8'h00;
    localparam logic [CFG_AW-1:0] A_SET_SEC = 8'h04;
    localparam logic [CFG_AW-1:0] A_OFFSET = 8'h08;
    localparam logic [CFG_AW-1:0] A_ENABLE = 8'h0C;
    localparam logic [CFG_AW-1:0] A_STATUS = 8'h10;
    localparam logic [CFG_AW-1:0] A_TIME_SEC = 8'h14;
    localparam logic [CFG_AW-1:0] A_TIME_CYC = 8'h18;
    localparam int XBAR_BIT = 7;
    localparam int CTL_START = 0;
    localparam int CTL_STOP = 1;
    localparam logic [NSTR-1:0] ENABLE_RST = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {
        AL_IDLE = 2'b00,
        AL_SEEK = 2'b01,
        AL_HOLD = 2'b10,
        AL_RUN = 2'b11
    } pboa_align_e;

    function automatic logic pboa_is_xbar(input logic [CFG_AW-1:0] a);
        return a[XBAR_BIT];
    endfunction : pboa_is_xbar

    function automatic logic [SEL_W-1:0] pboa_xbar_idx(
        input logic [CFG_AW-1:0] a);
        return a[SEL_W+1:2];
    endfunction : pboa_xbar_idx
endpackage : pboa_pkg

//--- core/pboa_link_if.sv
/*
 * Link between the output module and the processing system.
 * Assumes both ends run on their own copy of the 125 MHz reference.
 */
`timescale 1ns/1ps
interface pboa_link_if;
    import pboa_pkg::*;
    logic processor_reference_clock;
    logic processor_second_tick;
    logic replay_clock;
    logic [NSTR-1:0] reconstructed_stream;
    logic replay_second_tick;
    logic replay_valid_flag;
    logic requested_time_second_tick;
    logic requested_time_monitor;

    modport dev (
        input processor_reference_clock,
        input processor_second_tick,
        output replay_clock,
        output reconstructed_stream,
        output replay_second_tick,
        output replay_valid_flag,
        output requested_time_second_tick,
        output requested_time_monitor
    );

    modport proc (
        output processor_reference_clock,
        output processor_second_tick,
        input replay_clock,
        input reconstructed_stream,
        input replay_second_tick,
        input replay_valid_flag,
        input requested_time_second_tick,
        input requested_time_monitor
    );
endinterface : pboa_link_if

//--- core/pboa_delay_line.sv
/*
 * Shared delay buffer for streams, second tick and valid flag, indexed
 * in replay bit periods. Output lags input by one plus delay_in periods.
 * Assumes shift_en_in is a one-cycle pulse per replay bit.
 */
`timescale 1ns/1ps
module pboa_delay_line (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic shift_en_in,
    input wire logic flush_in,
    input wire logic [pboa_pkg::WORD_W-1:0] word_in,
    input wire logic [pboa_pkg::DLY_AW-1:0] delay_in,
    output logic [pboa_pkg::WORD_W-1:0] word_out
);
    import pboa_pkg::*;

    typedef struct packed {
        logic [DLY_DEPTH-1:0][WORD_W-1:0] mem;
        logic [DLY_AW-1:0] wptr;
        logic [WORD_W-1:0] dout;
    } pboa_dl_s;

    pboa_dl_s q;
    pboa_dl_s n;

    always_comb begin
        n = q;
        if (flush_in) begin
            // stale words from an earlier run must never reappear
            n.mem = '0;
            n.dout = '0;
        end else if (shift_en_in) begin
            n.mem[q.wptr] = word_in; // [R20]
            n.wptr = q.wptr + 1'b1;
            // read before write: zero delay still lags one period [R3]
            n.dout = q.mem[q.wptr - delay_in - 1'b1]; // [R20]
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign word_out = q.dout;
endmodule : pboa_delay_line

//--- core/pboa_output_module.sv
/*
 * Playback output module: requested-time counter, bit-offset alignment of
 * replayed streams, crossbar and control registers on a plain port.
 * Assumes the replay source presents one 32-bit word per bit with its
 * on-second flag, faster than the bit rate, under a valid/ready pull.
 */
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// R1: nonzero offset delays streams, tick, valid
// R2: offset counted in bit periods
// R3: zero offset: both second ticks coincide
// R4: offset range covers plus/minus half second
// R5: counter setting and offset independent
// R6: valid flag moves with its bits
// R7: direct mode: processing side delays data
// R8: any chosen subset of streams reproduced
// R9: set command loads on next processor tick
// R10: counter runs on reference clock only
// R11: start emits streams aligned to counter
// R12: valid only while data aligned correctly
// R13: stop command ends stream output
// R14: output bits equal replayed input bits
// R15: processing side buffers its own input
// R16: only active streams need reproducing
// R17: crossbar maps any stream to outputs
// R18: replay tick marks the on-second bit
// R19: monitor pulse shows counter epoch
// R20: shared delay buffer in bit periods
module pboa_output_module #(
    parameter logic [31:0] SEC_CYC = pboa_pkg::SEC_CYC_DEF
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    pboa_link_if.dev link,
    input wire logic [pboa_pkg::CFG_AW-1:0] cfg_addr_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    output logic [31:0] cfg_rdata_out,
    input wire logic [pboa_pkg::NSTR-1:0] src_data_in,
    input wire logic src_tag_in,
    input wire logic src_valid_in,
    output logic src_ready_out
);
    import pboa_pkg::*;

    typedef struct packed {
        logic [1:0] pclk_sync;
        logic [1:0] ptick_sync;
        logic pclk_prev;
        logic [31:0] sec_set;
        logic pending;
        logic loaded;
        logic [31:0] sec;
        logic [31:0] cyc;
        logic [31:0] offset;
        logic [NSTR-1:0] enable;
        logic [NSTR-1:0][SEL_W-1:0] xsel;
        logic run;
        pboa_align_e al;
        logic [NSTR-1:0] hold_data;
        logic hold_tag;
        logic have;
        logic rclk;
        logic req_pre;
        logic req_tick;
        logic mon_pre;
        logic mon;
        logic [31:0] rd_data;
        logic src_ready;
    } pboa_om_s;

    pboa_om_s q;
    pboa_om_s n;
    logic bit_en;
    logic bit_fall;
    logic xfer;
    logic flush;
    logic [NSTR-1:0] xbar_data;
    logic [WORD_W-1:0] dl_din;
    logic [WORD_W-1:0] dl_dout;
    logic [31:0] fine;
    logic [31:0] coarse;
    logic [31:0] target;
    logic [31:0] rd_mux;

    assign bit_en = q.pclk_sync[1] & ~q.pclk_prev;
    assign bit_fall = ~q.pclk_sync[1] & q.pclk_prev;
    assign xfer = src_valid_in & q.src_ready;

    // low offset bits go through the buffer, the rest moves the seek point
    assign fine = {26'h000_0000, q.offset[DLY_AW-1:0]}; // [R2]
    assign coarse = q.offset - fine;
    assign target = coarse[31] ? coarse + SEC_CYC : coarse; // [R4]

    genvar gi;
    generate
        for (gi = 0; gi < NSTR; gi++) begin : g_xbar
            assign xbar_data[gi] =
                q.enable[gi] & q.hold_data[q.xsel[gi]]; // [R17] [R8] [R16]
        end
    endgenerate

    always_comb begin
        rd_mux = '0;
        if (pboa_is_xbar(cfg_addr_in)) begin
            rd_mux = {27'h000_0000, q.xsel[pboa_xbar_idx(cfg_addr_in)]};
        end else begin
            case (cfg_addr_in)
                A_SET_SEC: rd_mux = q.sec_set;
                A_OFFSET: rd_mux = q.offset;
                A_ENABLE: rd_mux = q.enable;
                A_STATUS: rd_mux = {28'h000_0000, q.al == AL_RUN,
                                    q.run, q.loaded, q.pending};
                A_TIME_SEC: rd_mux = q.sec;
                A_TIME_CYC: rd_mux = q.cyc;
                default: rd_mux = '0;
            endcase
        end
    end

    always_comb begin
        n = q;
        flush = 1'b0;
        dl_din = '0;
        n.pclk_sync = {q.pclk_sync[0], link.processor_reference_clock};
        n.ptick_sync = {q.ptick_sync[0], link.processor_second_tick};
        n.pclk_prev = q.pclk_sync[1];
        n.rd_data = cfg_rd_in ? rd_mux : '0;

        // later ticks are ignored unless a set command is pending
        if (bit_en) begin
            if (q.pending && q.ptick_sync[1]) begin
                n.sec = q.sec_set; // [R9]
                n.cyc = '0;
                n.loaded = 1'b1;
                n.pending = 1'b0;
            end else if (q.loaded) begin
                if (q.cyc == SEC_CYC - 1'b1) begin // [R10]
                    n.cyc = '0;
                    n.sec = q.sec + 1'b1;
                end else begin
                    n.cyc = q.cyc + 1'b1;
                end
            end
        end

        if (cfg_wr_in) begin
            if (pboa_is_xbar(cfg_addr_in)) begin
                n.xsel[pboa_xbar_idx(cfg_addr_in)] =
                    cfg_wdata_in[SEL_W-1:0]; // [R17]
            end else begin
                case (cfg_addr_in)
                    A_CTRL: begin
                        if (cfg_wdata_in[CTL_START]) begin
                            n.run = 1'b1; // [R11]
                            n.al = AL_SEEK;
                            n.have = 1'b0;
                            flush = 1'b1;
                        end
                        if (cfg_wdata_in[CTL_STOP]) begin
                            n.run = 1'b0; // [R13]
                            n.al = AL_IDLE;
                            n.have = 1'b0;
                            flush = 1'b1;
                        end
                    end
                    A_SET_SEC: begin
                        n.sec_set = cfg_wdata_in; // [R5]
                        n.pending = 1'b1; // [R9]
                    end
                    A_OFFSET: begin
                        // counter untouched; only the stream realigns
                        n.offset = cfg_wdata_in; // [R5] [R2]
                        if (q.run) begin
                            n.al = AL_SEEK; // [R12]
                            n.have = 1'b0;
                            flush = 1'b1;
                        end
                    end
                    A_ENABLE: n.enable = cfg_wdata_in; // [R8]
                    default: ;
                endcase
            end
        end

        if (xfer && n.run) begin
            if (n.al == AL_SEEK) begin
                // discard until the on-second word shows up
                if (src_tag_in) begin
                    n.hold_data = src_data_in; // [R14]
                    n.hold_tag = 1'b1;
                    n.have = 1'b1;
                    n.al = AL_HOLD;
                end
            end else if (n.al == AL_RUN) begin
                n.hold_data = src_data_in; // [R14]
                n.hold_tag = src_tag_in;
                n.have = 1'b1;
            end
        end

        if (bit_en && !flush) begin
            unique case (n.al)
                AL_IDLE, AL_SEEK: ;
                AL_HOLD: begin
                    // a word taken this cycle is not in xbar_data yet
                    if (q.have && n.loaded && n.cyc == target) begin // [R1]
                        dl_din = {1'b1, 1'b1, xbar_data}; // [R18] [R6]
                        n.have = 1'b0;
                        n.al = AL_RUN;
                    end
                end
                AL_RUN: begin
                    if (q.have) begin
                        dl_din = {1'b1, q.hold_tag, xbar_data}; // [R6] [R11]
                        n.have = 1'b0;
                    end else begin
                        // underrun loses alignment: drop valid, reseek
                        n.al = AL_SEEK; // [R12]
                        n.have = 1'b0;
                    end
                end
            endcase
            n.rclk = 1'b0;
            n.req_pre = n.loaded && n.cyc == '0;
            n.req_tick = q.req_pre; // [R3]
            n.mon_pre = n.loaded && n.cyc < MON_LEN;
            n.mon = q.mon_pre; // [R19]
        end else if (bit_fall) begin
            n.rclk = 1'b1;
        end
        n.src_ready = n.run && !n.have && n.al != AL_IDLE;
    end

    pboa_delay_line u_delay (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .shift_en_in(bit_en && !flush),
        .flush_in(flush),
        .word_in(dl_din),
        .delay_in(q.offset[DLY_AW-1:0]),
        .word_out(dl_dout)
    ); // [R20] [R1]

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            q <= '0;
            q.enable <= ENABLE_RST;
            for (int i = 0; i < NSTR; i++) begin
                q.xsel[i] <= SEL_W'(i);
            end
        end else begin
            q <= n;
        end
    end

    assign cfg_rdata_out = q.rd_data;
    assign src_ready_out = q.src_ready;
    assign link.replay_clock = q.rclk;
    assign link.reconstructed_stream = dl_dout[NSTR-1:0];
    assign link.replay_second_tick = dl_dout[NSTR];
    assign link.replay_valid_flag = dl_dout[NSTR+1];
    assign link.requested_time_second_tick = q.req_tick;
    assign link.requested_time_monitor = q.mon;
endmodule : pboa_output_module

//--- core/pboa_processing_system.sv
/*
 * Processing-system end: makes the reference clock and second tick by
 * dividing its own clock and captures replayed bits on the replay clock.
 * Assumes buffering and any direct-mode delay happen downstream.
 */
`timescale 1ns/1ps
module pboa_processing_system #(
    parameter logic [31:0] SEC_CYC = pboa_pkg::SEC_CYC_DEF
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    pboa_link_if.proc link,
    output logic [pboa_pkg::NSTR-1:0] cap_data_out,
    output logic cap_tick_out,
    output logic cap_valid_out,
    output logic cap_req_tick_out,
    output logic cap_mon_out,
    output logic cap_stb_out
);
    import pboa_pkg::*;

    localparam int CAP_W = NSTR + 4;

    typedef struct packed {
        logic [7:0] div;
        logic pclk;
        logic [31:0] pcyc;
        logic ptick;
        logic [1:0] rclk_sync;
        logic rclk_prev;
        logic [1:0][CAP_W-1:0] d_sync;
        logic [CAP_W-1:0] cap;
        logic stb;
    } pboa_ps_s;

    pboa_ps_s q;
    pboa_ps_s n;

    always_comb begin
        n = q;
        n.div = q.div + 1'b1;
        if (q.div == 8'(PROC_HALF - 1)) begin
            n.div = '0;
            n.pclk = ~q.pclk;
            // tick changes on the falling edge so it is stable at the rise
            if (q.pclk) begin
                n.pcyc = (q.pcyc == SEC_CYC - 1'b1) ? '0 : q.pcyc + 1'b1;
                n.ptick = n.pcyc == '0;
            end
        end
        n.rclk_sync = {q.rclk_sync[0], link.replay_clock};
        n.rclk_prev = q.rclk_sync[1];
        n.d_sync[0] = {link.requested_time_monitor,
                       link.requested_time_second_tick,
                       link.replay_valid_flag, link.replay_second_tick,
                       link.reconstructed_stream};
        n.d_sync[1] = q.d_sync[0];
        n.stb = q.rclk_sync[1] & ~q.rclk_prev;
        if (n.stb) begin
            // downstream buffer absorbs offset from its own second
            n.cap = q.d_sync[1]; // [R15] [R7]
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign link.processor_reference_clock = q.pclk;
    assign link.processor_second_tick = q.ptick;
    assign cap_data_out = q.cap[NSTR-1:0];
    assign cap_tick_out = q.cap[NSTR];
    assign cap_valid_out = q.cap[NSTR+1];
    assign cap_req_tick_out = q.cap[NSTR+2];
    assign cap_mon_out = q.cap[NSTR+3];
    assign cap_stb_out = q.stb;
endmodule : pboa_processing_system

//--- tb/pboa_link_props.sv
/*
 * Link checker for the playback output pair.
 * Assumes plain link signals, all on the 125 MHz reference clock.
 */
`timescale 1ns/1ps
module pboa_link_props #(
    parameter int SEC_CYC = 200
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic processor_reference_clock,
    input wire logic processor_second_tick,
    input wire logic replay_clock,
    input wire logic [pboa_pkg::NSTR-1:0] reconstructed_stream,
    input wire logic replay_second_tick,
    input wire logic replay_valid_flag,
    input wire logic requested_time_second_tick,
    input wire logic requested_time_monitor
);
    import pboa_pkg::*;
    logic [15:0] gap;
    logic [15:0] mon_len;
    logic seen;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // gap counts reference cycles since the last requested tick
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gap <= '0;
            mon_len <= '0;
            seen <= 1'b0;
        end else begin
            gap <= $rose(requested_time_second_tick) ? 16'h0001 : gap + 1'b1;
            mon_len <= requested_time_monitor ? mon_len + 1'b1 : 16'h0000;
            seen <= seen | $rose(requested_time_second_tick);
        end
    end

    ref_clk_half_a: assert property (
        $rose(processor_reference_clock) |->
        processor_reference_clock [*8] ##1 !processor_reference_clock)
        else $error("processor clock high time wrong");
    tick_at_fall_a: assert property (
        $changed(processor_second_tick) |-> $fell(processor_reference_clock))
        else $error("processor tick moved off clock fall");
    replay_clk_a: assert property (
        $rose(replay_clock) |-> replay_clock [*7] ##[1:2] !replay_clock)
        else $error("replay clock high time wrong");
    data_at_fall_a: assert property (
        replay_valid_flag && $past(replay_valid_flag) &&
        !$stable(reconstructed_stream) |-> $fell(replay_clock))
        else $error("stream changed off replay clock fall");
    valid_with_tick_a: assert property (
        $rose(replay_valid_flag) |-> replay_second_tick)
        else $error("valid rose without replay tick");
    req_tick_len_a: assert property (
        $rose(requested_time_second_tick) |->
        requested_time_second_tick [*8] ##1 requested_time_second_tick [*8]
        ##1 !requested_time_second_tick)
        else $error("requested tick not one bit long");
    req_tick_gap_a: assert property (
        $rose(requested_time_second_tick) && seen |->
        gap == 16'(SEC_CYC * 16))
        else $error("requested tick spacing wrong");
    mon_len_a: assert property (
        $fell(requested_time_monitor) |-> mon_len == 16'(MON_LEN * 16))
        else $error("monitor pulse length wrong");

    cover property ($rose(replay_valid_flag));
    cover property (replay_second_tick && requested_time_second_tick);
    cover property ($fell(requested_time_monitor));
endmodule : pboa_link_props

//--- tb/tb_top.sv
/*
 * Bench for the output module and processing system back to back:
 * control port tasks, a tape-like replay source, captured link checks.
 * Assumes design and checker files are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    import pboa_pkg::*;
    localparam int SEC = 200;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [CFG_AW-1:0] cfg_addr_in = '0;
    logic [31:0] cfg_wdata_in = '0;
    logic cfg_wr_in = 1'b0;
    logic cfg_rd_in = 1'b0;
    logic src_valid_in = 1'b0;
    logic [31:0] cfg_rdata_out, src_data_in, cap_data_out, rd, w0;
    logic src_tag_in, src_ready_out, cap_tick_out, cap_valid_out;
    logic cap_req_tick_out, cap_mon_out, cap_stb_out;
    logic [7:0] pos = '0;
    int errors = 0;
    int tests_run = 0;
    int n;
    int offs[5] = '{0, 5, -5, 100, -100};
    pboa_link_if link();

    always #4 ref_clk_in = ~ref_clk_in;

    // source runs ahead of the bit rate, so seeking costs little time
    function automatic logic [31:0] word_at(input logic [7:0] k);
        return {8'hA5, k, ~k, k};
    endfunction : word_at
    assign src_data_in = word_at(pos);
    assign src_tag_in = (pos == 8'h00);
    always @(posedge ref_clk_in) begin
        if (src_valid_in && src_ready_out) begin
            pos <= (pos == 8'(SEC - 1)) ? 8'h00 : pos + 8'h01;
        end
    end

    pboa_output_module #(.SEC_CYC(32'(SEC))) i_pboa_output_module (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .link(link),
        .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
        .cfg_rdata_out(cfg_rdata_out), .src_data_in(src_data_in),
        .src_tag_in(src_tag_in), .src_valid_in(src_valid_in),
        .src_ready_out(src_ready_out));
    pboa_processing_system #(.SEC_CYC(32'(SEC))) i_pboa_processing_system (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .link(link),
        .cap_data_out(cap_data_out), .cap_tick_out(cap_tick_out),
        .cap_valid_out(cap_valid_out), .cap_req_tick_out(cap_req_tick_out),
        .cap_mon_out(cap_mon_out), .cap_stb_out(cap_stb_out));
    pboa_link_props #(.SEC_CYC(SEC)) i_pboa_link_props (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .processor_reference_clock(link.processor_reference_clock),
        .processor_second_tick(link.processor_second_tick),
        .replay_clock(link.replay_clock),
        .reconstructed_stream(link.reconstructed_stream),
        .replay_second_tick(link.replay_second_tick),
        .replay_valid_flag(link.replay_valid_flag),
        .requested_time_second_tick(link.requested_time_second_tick),
        .requested_time_monitor(link.requested_time_monitor));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        cfg_wr_in <= 1'b1;
        cfg_addr_in <= a;
        cfg_wdata_in <= d;
        @(posedge ref_clk_in);
        cfg_wr_in <= 1'b0;
    endtask : cfg_write

    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        cfg_rd_in <= 1'b1;
        cfg_addr_in <= a;
        @(posedge ref_clk_in);
        cfg_rd_in <= 1'b0;
        #1;
        d = cfg_rdata_out;
    endtask : cfg_read

    task automatic wait_stb;
        int w;
        w = 0;
        do begin
            @(posedge ref_clk_in);
            #1;
            w++;
        end while (cap_stb_out !== 1'b1 && w < 64);
    endtask : wait_stb

    // counts strobes until a requested tick or an aligned replay tick
    task automatic wait_ev(input bit req, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && (req ? cap_req_tick_out !== 1'b1 :
                (cap_tick_out & cap_valid_out) !== 1'b1)) begin
            wait_stb();
            cnt++;
        end
    endtask : wait_ev

    task automatic final_report;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #800000;
        errors++;
        final_report();
    end

    initial begin
        w0 = word_at(8'h00);
        repeat (4) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        src_valid_in <= 1'b1;
        cfg_read(A_STATUS, rd);
        check(rd, 32'h0000_0000);
        cfg_read(A_ENABLE, rd);
        check(rd, ENABLE_RST);
        cfg_read(8'h94, rd);
        check(rd, 32'h0000_0005);
        cfg_write(8'h40, 32'hFFFF_FFFF);
        cfg_read(8'h40, rd);
        check(rd, 32'h0000_0000);
        cfg_write(A_SET_SEC, 32'h0000_0005);
        cfg_read(A_STATUS, rd);
        check(rd & 32'h1, 32'h1);
        cfg_write(A_CTRL, 32'h0000_0001);
        wait_ev(1'b1, 600, n);
        check(32'(cap_mon_out), 32'h1);
        cfg_read(A_TIME_SEC, rd);
        check(rd, 32'h0000_0005);
        cfg_read(A_STATUS, rd);
        check(rd & 32'h7, 32'h6);
        wait_stb();
        wait_ev(1'b1, 250, n);
        cfg_read(A_TIME_SEC, rd);
        check(rd, 32'h0000_0006);
        foreach (offs[i]) begin
            cfg_write(A_OFFSET, offs[i]);
            wait_stb();
            check(32'(cap_valid_out), 32'h0);
            wait_ev(1'b0, 500, n);
            wait_ev(1'b1, 250, n);
            wait_ev(1'b0, 250, n);
            check(32'(n), 32'((offs[i] + SEC) % SEC));
            check(cap_data_out, w0);
            wait_stb();
            check(cap_data_out, word_at(8'h01));
            check(32'(cap_valid_out), 32'h1);
            cfg_read(A_STATUS, rd);
            check(rd & 32'h3, 32'h2);
        end
        cfg_write(8'h80, 32'h0000_001F);
        cfg_write(A_ENABLE, 32'h0000_00FF);
        wait_stb();
        wait_ev(1'b0, 250, n);
        check(cap_data_out, (w0 & 32'hFE) | 32'(w0[31]));
        cfg_write(A_CTRL, 32'h0000_0002);
        repeat (3) wait_stb();
        check(cap_data_out, 32'h0000_0000);
        check(32'(cap_valid_out), 32'h0);
        cfg_read(A_STATUS, rd);
        check(rd & 32'h4, 32'h0);
        final_report();
    end
endmodule : tb_top
